// File: design/ddc_defs.svh
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH
`define DDC_ADDR_W 13
`define DDC_ADDR_ALIGN 13'h100
`define DDC_ADDR_FIR 13'h102
`define DDC_ADDR_HB 13'h103
`define DDC_ADDR_TUNER 13'h11d
`define DDC_ADDR_TW0 13'h11e
`define DDC_ADDR_TW1 13'h11f
`define DDC_ADDR_TW2 13'h120
`define DDC_ADDR_TW3 13'h121
`define DDC_ADDR_PO0 13'h122
`define DDC_ADDR_PO1 13'h123
`define DDC_BIT_NCO_ARMED 1
`define DDC_BIT_HB_ARMED 2
`define DDC_BIT_NCO_SYNC_EN 3
`define DDC_BIT_NCO_SYNC_ONCE 4
`define DDC_BIT_HB_SYNC_EN 5
`define DDC_BIT_HB_SYNC_ONCE 6
`define DDC_BIT_FIR_EN 0
`define DDC_BIT_HB_HIGHPASS 1
`define DDC_BIT_HB_REVERSE 2
`define DDC_BIT_HB_DEC_PHASE 3
`define DDC_BIT_TUNE_EN 0
`define DDC_BIT_DITHER_EN 1
`define DDC_RST_BYTE 8'h00
`define DDC_LFSR_SEED 16'h0001
`define DDC_DITHER_OFF 2'h2
`define DDC_HB_TAPS 19
`define DDC_FIR_TAPS 66
`define DDC_FIR_HALF 33
`define DDC_HB_SHIFT 20
`define DDC_FIR_SHIFT 21
`define DDC_MIX_SHIFT 13
`endif

// File: design/ddc_pkg.sv
package ddc_pkg;
  typedef logic signed [15:0] ddc_smp_t;
  typedef struct packed {
    ddc_smp_t a_i;
    ddc_smp_t a_q;
    ddc_smp_t b_i;
    ddc_smp_t b_q;
  } ddc_iq_t;
  // quarter-wave sine, peak kept 3 below max so dither never wraps
  localparam ddc_smp_t DDC_SIN_LUT [0:16] = '{
    16'sd0, 16'sd3212, 16'sd6393, 16'sd9512, 16'sd12539, 16'sd15447,
    16'sd18205, 16'sd20787, 16'sd23170, 16'sd25329, 16'sd27245,
    16'sd28898, 16'sd30273, 16'sd31356, 16'sd32137, 16'sd32609,
    16'sd32764};
  localparam logic signed [19:0] DDC_HB_COEF [0:5] = '{
    20'sd844, -20'sd6189, 20'sd25080, -20'sd79170, 20'sd321584,
    20'sd524287};
  localparam logic signed [20:0] DDC_FIR_COEF [0:32] = '{
    21'sd383, 21'sd1431, 21'sd1950, 21'sd96, -21'sd2661, -21'sd1750,
    21'sd2476, 21'sd2388, -21'sd3867, -21'sd5150, 21'sd3788, 21'sd7513,
    -21'sd4511, -21'sd11914, 21'sd3650, 21'sd16484, -21'sd2818,
    -21'sd23200, -21'sd48, 21'sd30748, 21'sd3976, -21'sd41019,
    -21'sd11147, 21'sd53608, 21'sd21818, -21'sd71611, -21'sd40300,
    21'sd98830, 21'sd74264, -21'sd152696, -21'sd161248, 21'sd337056,
    21'sd922060};
endpackage

// File: design/ddc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddc_defs.svh"
module ddc_top #(
  parameter int ADC_W = 14
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [`DDC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic signed [ADC_W-1:0] adc_a,
  input wire logic signed [ADC_W-1:0] adc_b,
  input wire logic adc_valid,
  output logic adc_ready,
  input wire logic sync_in,
  output ddc_pkg::ddc_iq_t out_data,
  output logic out_valid,
  input wire logic out_ready
);
  generate
    if (ADC_W < 2 || ADC_W > 16) begin : g_bad_width
      $error("ADC_W must lie in 2..16");
    end
  endgenerate

  logic [7:0] align_reg;
  logic [7:0] fir_ctrl_reg;
  logic [7:0] hb_ctrl_reg;
  logic [7:0] tuner_reg;
  logic [7:0] tw_reg [0:3];
  logic [7:0] po_reg [0:1];
  logic [31:0] tuning_word;
  logic [15:0] phase_offset_word;
  logic align_wr;
  logic nco_armed_reg;
  logic hb_armed_reg;
  logic ready_reg;
  logic adv;
  logic nco_fire;
  logic hb_fire;

  assign tuning_word = {tw_reg[3], tw_reg[2], tw_reg[1], tw_reg[0]};
  assign phase_offset_word = {po_reg[1], po_reg[0]};
  assign align_wr = reg_wr_en && (reg_addr == `DDC_ADDR_ALIGN);
  // the whole path moves one sample per accepted converter word
  assign adv = adc_valid && ready_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      align_reg <= `DDC_RST_BYTE;
      fir_ctrl_reg <= `DDC_RST_BYTE;
      hb_ctrl_reg <= `DDC_RST_BYTE;
      tuner_reg <= `DDC_RST_BYTE;
      for (int k = 0; k < 4; k++) begin
        tw_reg[k] <= `DDC_RST_BYTE;
      end
      po_reg[0] <= `DDC_RST_BYTE;
      po_reg[1] <= `DDC_RST_BYTE;
    end else if (reg_wr_en) begin
      if (reg_addr == `DDC_ADDR_ALIGN) begin
        align_reg <= reg_wdata;
      end else if (reg_addr == `DDC_ADDR_FIR) begin
        fir_ctrl_reg <= reg_wdata;
      end else if (reg_addr == `DDC_ADDR_HB) begin
        hb_ctrl_reg <= reg_wdata;
      end else if (reg_addr == `DDC_ADDR_TUNER) begin
        tuner_reg <= reg_wdata;
      end else if (reg_addr == `DDC_ADDR_TW0) begin
        tw_reg[0] <= reg_wdata;
      end else if (reg_addr == `DDC_ADDR_TW1) begin
        tw_reg[1] <= reg_wdata;
      end else if (reg_addr == `DDC_ADDR_TW2) begin
        tw_reg[2] <= reg_wdata;
      end else if (reg_addr == `DDC_ADDR_TW3) begin
        tw_reg[3] <= reg_wdata;
      end else if (reg_addr == `DDC_ADDR_PO0) begin
        po_reg[0] <= reg_wdata;
      end else if (reg_addr == `DDC_ADDR_PO1) begin
        po_reg[1] <= reg_wdata;
      end
    end
  end

  // armed flags overlay bits 1 and 2 of align_control on readback
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      if (reg_addr == `DDC_ADDR_ALIGN) begin
        reg_rdata <= {align_reg[7:3], hb_armed_reg, nco_armed_reg,
                      align_reg[0]};
      end else if (reg_addr == `DDC_ADDR_FIR) begin
        reg_rdata <= fir_ctrl_reg;
      end else if (reg_addr == `DDC_ADDR_HB) begin
        reg_rdata <= hb_ctrl_reg;
      end else if (reg_addr == `DDC_ADDR_TUNER) begin
        reg_rdata <= tuner_reg;
      end else if (reg_addr == `DDC_ADDR_TW0) begin
        reg_rdata <= tw_reg[0];
      end else if (reg_addr == `DDC_ADDR_TW1) begin
        reg_rdata <= tw_reg[1];
      end else if (reg_addr == `DDC_ADDR_TW2) begin
        reg_rdata <= tw_reg[2];
      end else if (reg_addr == `DDC_ADDR_TW3) begin
        reg_rdata <= tw_reg[3];
      end else if (reg_addr == `DDC_ADDR_PO0) begin
        reg_rdata <= po_reg[0];
      end else if (reg_addr == `DDC_ADDR_PO1) begin
        reg_rdata <= po_reg[1];
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  assign nco_fire = adv && sync_in && nco_armed_reg;
  assign hb_fire = adv && sync_in && hb_armed_reg;

  // a write sets the armed flag to its enable bit; in first-pulse mode the pulse then disarms
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nco_armed_reg <= 1'b0;
    end else if (align_wr) begin
      nco_armed_reg <= reg_wdata[`DDC_BIT_NCO_SYNC_EN];
    end else if (nco_fire && align_reg[`DDC_BIT_NCO_SYNC_ONCE]) begin
      nco_armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hb_armed_reg <= 1'b0;
    end else if (align_wr) begin
      hb_armed_reg <= reg_wdata[`DDC_BIT_HB_SYNC_EN];
    end else if (hb_fire && align_reg[`DDC_BIT_HB_SYNC_ONCE]) begin
      hb_armed_reg <= 1'b0;
    end
  end

  logic [31:0] phase_acc_reg;
  logic [31:0] phase_now;
  logic [31:0] lut_phase;
  logic [15:0] lfsr_reg;
  logic [1:0] dith;
  logic signed [13:0] cos_amp;
  logic signed [13:0] sin_amp;

  function automatic logic signed [13:0] qwave(input logic [1:0] q,
                                               input logic [3:0] i,
                                               input logic [1:0] d);
    logic [4:0] k;
    logic signed [15:0] v;
    logic signed [16:0] s;
    k = q[0] ? 5'd16 - {1'b0, i} : {1'b0, i};
    v = ddc_pkg::DDC_SIN_LUT[k];
    if (q[1]) begin
      v = -v;
    end
    s = 17'(v) + 17'({15'h0000, d});
    return s[15:2];
  endfunction

  // restart at zero, so the lookup sees exactly the phase offset
  assign phase_now = nco_fire ? 32'h0000_0000 : phase_acc_reg;
  assign lut_phase = phase_now + {phase_offset_word, 16'h0000};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_acc_reg <= 32'h0000_0000;
    end else if (adv) begin
      // signed word wraps modulo 2^32, negative words tune downwards
      phase_acc_reg <= phase_now + tuning_word;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lfsr_reg <= `DDC_LFSR_SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0],
                   lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end

  // random rounding spreads quantisation spurs into the noise floor
  assign dith = tuner_reg[`DDC_BIT_DITHER_EN] ? lfsr_reg[1:0]
                                              : `DDC_DITHER_OFF;
  assign sin_amp = qwave(lut_phase[31:30], lut_phase[29:26], dith);
  assign cos_amp = qwave(lut_phase[31:30] + 2'h1, lut_phase[29:26], dith);

  logic signed [15:0] xs_a;
  logic signed [15:0] xs_b;
  logic signed [29:0] p_ai;
  logic signed [29:0] p_aq;
  logic signed [29:0] p_bi;
  logic signed [29:0] p_bq;
  logic signed [15:0] mix_reg [0:3];
  logic mix_v;

  assign xs_a = 16'(adc_a) <<< (16 - ADC_W);
  assign xs_b = 16'(adc_b) <<< (16 - ADC_W);
  assign p_ai = xs_a * cos_amp;
  assign p_aq = -(xs_a * sin_amp);
  assign p_bi = xs_b * cos_amp;
  assign p_bq = -(xs_b * sin_amp);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mix_v <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        mix_reg[k] <= 16'sh0000;
      end
    end else if (adv) begin
      mix_v <= 1'b1;
      if (tuner_reg[`DDC_BIT_TUNE_EN]) begin
        mix_reg[0] <= p_ai[`DDC_MIX_SHIFT+15:`DDC_MIX_SHIFT];
        mix_reg[1] <= p_aq[`DDC_MIX_SHIFT+15:`DDC_MIX_SHIFT];
        mix_reg[2] <= p_bi[`DDC_MIX_SHIFT+15:`DDC_MIX_SHIFT];
        mix_reg[3] <= p_bq[`DDC_MIX_SHIFT+15:`DDC_MIX_SHIFT];
      end else begin
        mix_reg[0] <= xs_a;
        mix_reg[1] <= 16'sh0000;
        mix_reg[2] <= xs_b;
        mix_reg[3] <= 16'sh0000;
      end
    end
  end

  logic hb_adv;
  logic hb_out_en;
  logic hb_ph_reg;
  logic rev_ph_reg;
  logic hb_v;
  logic fir_adv;
  logic fir_v;
  logic push;

  // no enable bit exists for the half-band: every sample enters it
  assign hb_adv = adv && mix_v;
  assign hb_out_en = hb_adv && !hb_ph_reg;
  assign fir_adv = adv && hb_v;
  assign push = adv && fir_v;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hb_ph_reg <= 1'b0;
    end else if (hb_fire) begin
      hb_ph_reg <= hb_ctrl_reg[`DDC_BIT_HB_DEC_PHASE];
    end else if (hb_adv) begin
      hb_ph_reg <= !hb_ph_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rev_ph_reg <= 1'b0;
    end else if (hb_adv) begin
      rev_ph_reg <= !rev_ph_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hb_v <= 1'b0;
      fir_v <= 1'b0;
    end else if (adv) begin
      hb_v <= hb_out_en;
      fir_v <= fir_adv;
    end
  end

  generate
    for (genvar s = 0; s < 4; s++) begin : g_stream
      logic signed [15:0] hb_in;
      logic signed [15:0] hb_dl [0:`DDC_HB_TAPS-1];
      logic signed [16:0] hb_pair [0:4];
      logic signed [41:0] hb_term [0:4];
      logic signed [41:0] hb_ctr;
      logic signed [41:0] hb_sum;
      logic signed [15:0] hb_out_reg;
      logic signed [15:0] fir_dl [0:`DDC_FIR_TAPS-1];
      logic signed [16:0] fir_pair [0:`DDC_FIR_HALF-1];
      logic signed [45:0] fir_term [0:`DDC_FIR_HALF-1];
      logic signed [45:0] fir_sum;
      logic signed [15:0] fir_out_reg;

      // alternate sign mirrors the spectrum about a quarter of the rate
      assign hb_in = (hb_ctrl_reg[`DDC_BIT_HB_REVERSE] && rev_ph_reg)
                     ? -mix_reg[s] : mix_reg[s];

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          for (int k = 0; k < `DDC_HB_TAPS; k++) begin
            hb_dl[k] <= 16'sh0000;
          end
        end else if (hb_adv) begin
          hb_dl[0] <= hb_in;
          for (int k = 1; k < `DDC_HB_TAPS; k++) begin
            hb_dl[k] <= hb_dl[k-1];
          end
        end
      end

      // only even taps and the centre are nonzero: half the multipliers
      always_comb begin
        for (int j = 0; j < 5; j++) begin
          hb_pair[j] = 17'(hb_dl[2*j]) + 17'(hb_dl[18-2*j]);
          hb_term[j] = ddc_pkg::DDC_HB_COEF[j] * hb_pair[j];
        end
        hb_ctr = ddc_pkg::DDC_HB_COEF[5] * hb_dl[9];
        hb_sum = hb_term[0] + hb_term[1] + hb_term[2] + hb_term[3]
                 + hb_term[4];
        if (hb_ctrl_reg[`DDC_BIT_HB_HIGHPASS]) begin
          hb_sum = hb_ctr - hb_sum;
        end else begin
          hb_sum = hb_ctr + hb_sum;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          hb_out_reg <= 16'sh0000;
        end else if (hb_out_en) begin
          hb_out_reg <= hb_sum[`DDC_HB_SHIFT+15:`DDC_HB_SHIFT];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          for (int k = 0; k < `DDC_FIR_TAPS; k++) begin
            fir_dl[k] <= 16'sh0000;
          end
        end else if (fir_adv) begin
          fir_dl[0] <= hb_out_reg;
          for (int k = 1; k < `DDC_FIR_TAPS; k++) begin
            fir_dl[k] <= fir_dl[k-1];
          end
        end
      end

      always_comb begin
        fir_sum = 46'sh0;
        for (int j = 0; j < `DDC_FIR_HALF; j++) begin
          fir_pair[j] = 17'(fir_dl[j]) + 17'(fir_dl[`DDC_FIR_TAPS-1-j]);
          fir_term[j] = ddc_pkg::DDC_FIR_COEF[j] * fir_pair[j];
          fir_sum = fir_sum + fir_term[j];
        end
      end

      // filter ends on the half-band output, so it never runs without it
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          fir_out_reg <= 16'sh0000;
        end else if (fir_adv) begin
          if (fir_ctrl_reg[`DDC_BIT_FIR_EN]) begin
            fir_out_reg <= fir_sum[`DDC_FIR_SHIFT+15:`DDC_FIR_SHIFT];
          end else begin
            fir_out_reg <= hb_out_reg;
          end
        end
      end
    end
  endgenerate

  ddc_pkg::ddc_iq_t in_word;
  ddc_pkg::ddc_iq_t spare_reg;
  logic spare_v;
  logic pop;
  logic [1:0] cnt_next;

  // one driver for the whole word, a_i lands in the top bits
  assign in_word = {g_stream[0].fir_out_reg, g_stream[1].fir_out_reg,
                    g_stream[2].fir_out_reg, g_stream[3].fir_out_reg};
  assign pop = out_valid && out_ready;
  assign cnt_next = 2'({1'b0, out_valid} + {1'b0, spare_v}
                       + {1'b0, push} - {1'b0, pop});

  // two entries: head is the output register, spare catches a stall
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_data <= '0;
      out_valid <= 1'b0;
      spare_reg <= '0;
      spare_v <= 1'b0;
    end else begin
      if (push) begin
        if (!out_valid || (pop && !spare_v)) begin
          out_data <= in_word;
          out_valid <= 1'b1;
        end else if (pop) begin
          out_data <= spare_reg;
          spare_reg <= in_word;
        end else begin
          spare_reg <= in_word;
          spare_v <= 1'b1;
        end
      end else if (pop) begin
        if (spare_v) begin
          out_data <= spare_reg;
          spare_v <= 1'b0;
        end else begin
          out_valid <= 1'b0;
        end
      end
    end
  end

  // a full buffer freezes the whole path, so nothing is dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ready_reg <= 1'b1;
    end else begin
      ready_reg <= (cnt_next != 2'h2);
    end
  end

  assign adc_ready = ready_reg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_nco_fire;
    adv && nco_fire;
  endsequence
  sequence s_hb_fire;
    hb_fire;
  endsequence

  property p_nco_restart;
    s_nco_fire |=> phase_acc_reg == $past(tuning_word);
  endproperty
  a_nco_restart: assert property (p_nco_restart)
    else $error("phase did not restart on alignment");

  property p_acc_step;
    adv && !nco_fire |=>
      phase_acc_reg == $past(phase_acc_reg) + $past(tuning_word);
  endproperty
  a_acc_step: assert property (p_acc_step)
    else $error("phase accumulator step wrong");

  property p_nco_bypass;
    adv && !tuner_reg[`DDC_BIT_TUNE_EN] |=>
      mix_reg[1] == 16'sh0000 && mix_reg[0] == $past(xs_a);
  endproperty
  a_nco_bypass: assert property (p_nco_bypass)
    else $error("bypassed tuner altered samples");

  property p_nco_once;
    s_nco_fire ##0 (align_reg[`DDC_BIT_NCO_SYNC_ONCE] && !align_wr)
      |=> !nco_armed_reg ##1 (!nco_fire || $past(align_wr));
  endproperty
  a_nco_once: assert property (p_nco_once)
    else $error("first-pulse alignment fired twice");

  property p_hb_toggle;
    hb_adv && !hb_fire |=> hb_ph_reg != $past(hb_ph_reg);
  endproperty
  a_hb_toggle: assert property (p_hb_toggle)
    else $error("half-band phase did not alternate");

  property p_hb_sync;
    s_hb_fire |=> hb_ph_reg == $past(hb_ctrl_reg[`DDC_BIT_HB_DEC_PHASE]);
  endproperty
  a_hb_sync: assert property (p_hb_sync)
    else $error("half-band phase not restarted");

  property p_fir_bypass;
    fir_adv && !fir_ctrl_reg[`DDC_BIT_FIR_EN] |=>
      g_stream[0].fir_out_reg == $past(g_stream[0].hb_out_reg);
  endproperty
  a_fir_bypass: assert property (p_fir_bypass)
    else $error("bypassed filter altered data");

  property p_buf_full;
    out_valid && spare_v |-> !adc_ready;
  endproperty
  a_buf_full: assert property (p_buf_full)
    else $error("ready high while buffer full");

  property p_hold_stall;
    out_valid && !out_ready |=> out_valid && out_data == $past(out_data);
  endproperty
  a_hold_stall: assert property (p_hold_stall)
    else $error("output word changed during stall");
endmodule
`default_nettype wire

// File: tb/ddc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module ddc_far_end (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic hold,
  input wire logic [13:0] a,
  input wire logic [13:0] b,
  input wire logic adc_ready,
  output logic [13:0] adc_a,
  output logic [13:0] adc_b,
  output logic adc_valid,
  input wire logic out_valid,
  input wire ddc_pkg::ddc_iq_t out_data,
  output logic out_ready,
  output int n_in,
  output int n_out,
  output ddc_pkg::ddc_iq_t last
);
  int t = 0;
  logic gap;
  assign gap = slow && (t % 3 == 0);
  always @(posedge ref_clk) begin
    t <= t + 1;
    out_ready <= !rst && !hold && !(slow && t % 5 == 0);
    if (rst) begin
      adc_valid <= 1'b0;
      adc_a <= '0;
      adc_b <= '0;
      n_in <= 0;
      n_out <= 0;
    end else begin
      // a sample waits until taken; idle lines carry junk, not old data
      if (!adc_valid || adc_ready) begin
        adc_valid <= !gap;
        adc_a <= gap ? ~a : a;
        adc_b <= gap ? ~b : b;
      end
      if (adc_valid && adc_ready)
        n_in <= n_in + 1;
      if (out_valid && out_ready) begin
        n_out <= n_out + 1;
        last <= out_data;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddc_defs.svh"
module tb;
  typedef struct {
    logic [7:0] tun, hb, fir;
    logic [31:0] word;
    logic [15:0] ofs;
    int ai, aq, bi, bq, tol;
  } ddc_row_t;
  logic ref_clk = 1'b0;
  logic rst, reg_wr_en, reg_rd_en, sync_in, out_valid, out_ready;
  logic adc_valid, adc_ready, slow, hold;
  logic [12:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [13:0] adc_a, adc_b, a, b;
  ddc_pkg::ddc_iq_t out_data, last, snap;
  int n_in, n_out;
  int n_mismatch = 0;
  int checks = 0;
  ddc_row_t rows [9];
  logic [23:0] sy [4];

  ddc_top #(.ADC_W(14)) uut (.ref_clk(ref_clk), .rst(rst),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_a(adc_a),
    .adc_b(adc_b), .adc_valid(adc_valid), .adc_ready(adc_ready),
    .sync_in(sync_in), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready));
  ddc_far_end fe (.ref_clk(ref_clk), .rst(rst), .slow(slow), .hold(hold),
    .a(a), .b(b), .adc_ready(adc_ready), .adc_a(adc_a), .adc_b(adc_b),
    .adc_valid(adc_valid), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .n_in(n_in), .n_out(n_out), .last(last));

  always #2 ref_clk = ~ref_clk;

  task automatic stop_test;
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // filter rounding makes tuned results approximate, so allow a window
  task automatic near(input logic signed [15:0] s, input int e,
                      input int tol);
    if (s >= e - tol && s <= e + tol)
      chk(64'(e), 64'(e));
    else
      chk(64'(s), 64'(e));
  endtask

  task automatic wr(input logic [12:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = ad;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [12:0] ad, input logic [7:0] e);
    @(posedge ref_clk);
    #1;
    reg_addr = ad;
    reg_rd_en = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd_en = 1'b0;
    @(posedge ref_clk);
    #1;
    chk(64'(reg_rdata), 64'(e));
  endtask

  task automatic leave_reset;
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    @(posedge ref_clk);
    #1;
    chk(64'(out_valid), 64'h0);
    chk(64'(adc_ready), 64'h1);
  endtask

  task automatic run_row(input ddc_row_t r);
    int n0, i0, k;
    wr(`DDC_ADDR_TUNER, r.tun);
    wr(`DDC_ADDR_HB, r.hb);
    wr(`DDC_ADDR_FIR, r.fir);
    for (k = 0; k < 4; k++)
      wr(13'(`DDC_ADDR_TW0 + k), r.word[8*k+:8]);
    wr(`DDC_ADDR_PO0, r.ofs[7:0]);
    wr(`DDC_ADDR_PO1, r.ofs[15:8]);
    // restart the phase so the lookup sees only the programmed offset
    wr(`DDC_ADDR_ALIGN, 8'h08);
    sync_in = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    sync_in = 1'b0;
    n0 = n_out;
    i0 = n_in;
    k = 0;
    while (n_out < n0 + 100 && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    #1;
    chk(64'(k < 2000), 64'h1);
    near(last.a_i, r.ai, r.tol);
    near(last.a_q, r.aq, r.tol);
    near(last.b_i, r.bi, r.tol);
    near(last.b_q, r.bq, r.tol);
    near(16'(n_in - i0), 202, 6);
  endtask

  initial begin
    {rst, reg_wr_en, reg_rd_en, sync_in, slow, hold} = 6'h20;
    reg_addr = 13'h000;
    reg_wdata = 8'h00;
    a = 14'h03e8;
    b = 14'h3e0c;
    sy = '{24'h181a18, 24'h0a0a08, 24'h606460, 24'h242420};
    rows = '{
      '{8'h00, 8'h00, 8'h00, 32'h0, 16'h0, 4000, 0, -2001, 0, 0},
      '{8'h00, 8'h02, 8'h00, 32'h0, 16'h0, -1, 0, 0, 0, 0},
      '{8'h00, 8'h00, 8'h01, 32'h0, 16'h0, 4000, 0, -2002, 0, 0},
      '{8'h00, 8'h04, 8'h00, 32'h0, 16'h0, 0, 0, 0, 0, 1},
      '{8'h00, 8'h08, 8'h00, 32'h0, 16'h0, 4000, 0, -2001, 0, 0},
      '{8'h01, 8'h00, 8'h00, 32'h0, 16'h0, 4000, 0, -2000, 0, 4},
      '{8'h03, 8'h00, 8'h00, 32'h0, 16'h4000, 0, -4000, 0, 2000, 4},
      '{8'h03, 8'h00, 8'h00, 32'h0, 16'h8000, -4000, 0, 2000, 0, 4},
      '{8'h03, 8'h00, 8'h00, 32'h80000000, 16'h0, 0, 0, 0, 0, 4}
    };
    leave_reset;
    for (int k = 'h100; k <= 'h123; k++)
      rd(13'(k), 8'h00);
    for (int k = 0; k < 4; k++)
      wr(13'(`DDC_ADDR_TW0 + k), 8'(8'h11 * (k + 1)));
    wr(13'h101, 8'hff);
    for (int k = 0; k < 4; k++)
      rd(13'(`DDC_ADDR_TW0 + k), 8'(8'h11 * (k + 1)));
    rd(13'h101, 8'h00);
    // half-band realignment must load decimation phase 1 here
    wr(`DDC_ADDR_HB, 8'h08);
    foreach (sy[i]) begin
      wr(`DDC_ADDR_ALIGN, sy[i][7:0]);
      rd(`DDC_ADDR_ALIGN, sy[i][15:8]);
      sync_in = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      sync_in = 1'b0;
      rd(`DDC_ADDR_ALIGN, sy[i][23:16]);
    end
    foreach (rows[i]) begin
      slow = i[0];
      run_row(rows[i]);
    end
    hold = 1'b1;
    repeat (40) @(posedge ref_clk);
    #1;
    chk(64'(adc_ready), 64'h0);
    chk(64'(out_valid), 64'h1);
    snap = out_data;
    repeat (5) @(posedge ref_clk);
    #1;
    chk(out_data, snap);
    hold = 1'b0;
    run_row(rows[0]);
    rst = 1'b1;
    leave_reset;
    rd(`DDC_ADDR_TUNER, 8'h00);
    stop_test;
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    stop_test;
  end
endmodule
`default_nettype wire
